// ==== core/esr_pkg.sv ====
// Constants and carrier types of the extended service router.
package esr_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [13:0] ADDR_CMD_LEN = 14'h0000;
    localparam logic [13:0] ADDR_CTRL = 14'h0004;
    localparam logic [13:0] ADDR_RSP_LEN = 14'h0008;
    localparam logic [13:0] ADDR_RESULT = 14'h000c;
    localparam logic [1:0] CMD_AREA = 2'h1;
    localparam logic [1:0] RSP_AREA = 2'h2;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;

    // ****************************************************************
    // Router word layout and values
    // ****************************************************************
    localparam int DIR_BIT = 15;
    localparam int RSVD_BIT = 14;
    localparam int STAT_HI = 13;
    localparam int STAT_LO = 12;
    localparam logic [1:0] RSTAT_NORMAL = 2'h0;
    localparam logic [1:0] RSTAT_NO_SVC = 2'h1;
    localparam logic [1:0] RSTAT_ROUTER_ERR = 2'h2;
    localparam logic [11:0] SVC_UNIT_INFO = 12'h000;
    localparam logic [11:0] SVC_CLOCK_READ = 12'h001;
    localparam logic [11:0] SVC_CLOCK_SET = 12'h002;
    localparam logic [11:0] SVC_COMMON_LIMIT = 12'h100;
    localparam logic [11:0] SVC_MODEL_FIRST = 12'h400;
    localparam logic [11:0] SVC_MODEL_LAST = 12'h407;
    localparam logic [11:0] SVC_TRANS_CTRL = 12'h400;
    localparam logic [15:0] SUBCMD_RECIPE = 16'h0002;

    // ****************************************************************
    // Response codes and classes
    // ****************************************************************
    localparam logic [15:0] CODE_OK = 16'h0000;
    localparam logic [15:0] CODE_ONE_RECIPE = 16'h8024;
    localparam logic [15:0] CODE_PACKING = 16'h8030;
    typedef enum logic [1:0] {
        ESR_NORMAL = 2'h0,
        ESR_WARNING = 2'h1,
        ESR_CRITICAL = 2'h2,
        ESR_FATAL = 2'h3
    } esr_class_t;

    // ****************************************************************
    // Packet sizes (bytes) and unit information layout (words)
    // ****************************************************************
    localparam logic [10:0] LEN_MIN = 11'h002;
    localparam logic [10:0] LEN_MAX = 11'h400;
    localparam logic [10:0] LEN_ROUTER_ONLY = 11'h002;
    localparam logic [10:0] LEN_CODE_ONLY = 11'h004;
    localparam logic [10:0] LEN_UNIT_INFO = 11'h01e;
    localparam logic [8:0] UI_MFR = 9'h002;
    localparam logic [8:0] UI_MODEL = 9'h003;
    localparam logic [8:0] UI_FW = 9'h00c;
    localparam logic [8:0] UI_CRC_HI = 9'h00d;
    localparam logic [8:0] UI_CRC_LO = 9'h00e;

    // Request to an outside service handler
    typedef struct packed {
        logic valid;
        logic [3:0] handler;
        logic [11:0] service;
    } esr_svc_req_t;

    // Completion from an outside service handler
    typedef struct packed {
        logic done;
        logic [15:0] code;
    } esr_svc_rsp_t;
endpackage : esr_pkg

// ==== core/esr_router.sv ====
// Extended service router with AHB-Lite register and packet access.
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module esr_router #(
    parameter int WORDS = 512,
    parameter logic [15:0] MFR_CODE = 16'h00a5,   // Arbitrary identity value
    parameter logic [15:0] MODEL_CODE = 16'h005a, // Arbitrary identity value
    parameter logic [15:0] FW_REV = 16'h0001,
    parameter logic [31:0] ROM_CRC = 32'h0000_0000
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic memPacking,
    input wire logic oneRecipeNeeded,
    input wire esr_pkg::esr_svc_rsp_t svcRsp,
    output esr_pkg::esr_svc_req_t svcReq,
    output logic busy
);
    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // severity class from the top two code bits
    function automatic esr_pkg::esr_class_t codeClass(input logic [15:0] code);
        codeClass = esr_pkg::esr_class_t'(code[15:14]);
    endfunction : codeClass

    // Count of enabled recipes in a 64-bit selection
    function automatic logic [6:0] onesCount(input logic [63:0] v);
        onesCount = 7'h00;
        for (int i = 0; i < 64; i++) begin
            onesCount = onesCount + {6'h00, v[i]};
        end
    endfunction : onesCount

    typedef enum logic [2:0] {
        ESR_IDLE = 3'h0,
        ESR_DECODE = 3'h1,
        ESR_WAIT = 3'h3,
        ESR_BUILD = 3'h2,
        ESR_FINISH = 3'h6
    } esr_state_t;

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [15:0] cmdMem [WORDS];
    logic [15:0] rspMem [WORDS];
    logic [10:0] cmdLen_r;
    logic [10:0] rspLen_r;
    logic [10:0] workLen_r;
    logic [15:0] code_r;
    logic [1:0] rstat_r;
    logic [11:0] svc_r;
    logic done_r;
    logic [8:0] idx_r;
    esr_state_t state_r;
    esr_state_t state_nxt;

    // ****************************************************************
    // AHB-Lite slave: one wait state per transfer
    // ****************************************************************
    logic pend_r;
    logic pendWrite_r;
    logic [13:0] pendAddr_r;
    wire take = hsel && hready && htrans[1];
    wire [1:0] area = pendAddr_r[13:12];
    wire [8:0] wordIdx = pendAddr_r[10:2];
    wire inMem = (pendAddr_r[11] == 1'b0) && (32'(wordIdx) < WORDS);
    wire cmdHit = (area == esr_pkg::CMD_AREA) && inMem;
    wire rspHit = (area == esr_pkg::RSP_AREA) && inMem;
    wire busWr = pend_r && pendWrite_r;
    wire ctrlWr = busWr && (pendAddr_r == esr_pkg::ADDR_CTRL);
    wire startPulse = ctrlWr && hwdata[esr_pkg::CTRL_START_BIT];
    wire clearDone = ctrlWr && hwdata[esr_pkg::CTRL_CLEAR_BIT];
    esr_pkg::esr_class_t lastClass;
    assign lastClass = codeClass(code_r);
    logic [31:0] rdValue;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdValue = 32'h0000_0000;
        case (pendAddr_r)
            esr_pkg::ADDR_CMD_LEN: rdValue = {21'h0, cmdLen_r};
            esr_pkg::ADDR_CTRL: rdValue = {30'h0, done_r, busy};
            esr_pkg::ADDR_RSP_LEN: rdValue = {21'h0, rspLen_r};
            esr_pkg::ADDR_RESULT: rdValue = {11'h0, svc_r < esr_pkg::SVC_COMMON_LIMIT,
                rstat_r, lastClass, code_r};
            default: begin
                if (cmdHit) begin
                    rdValue = {16'h0, cmdMem[wordIdx]};
                end else if (rspHit) begin
                    rdValue = {16'h0, rspMem[wordIdx]};
                end
            end
        endcase
    end

    // Bus phases; writes take effect only at full-word size
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pend_r <= 1'b0;
            pendWrite_r <= 1'b0;
            pendAddr_r <= 14'h0000;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
        end else begin
            pend_r <= take;
            hreadyout <= !take;
            if (take) begin
                pendWrite_r <= hwrite && (hsize == 3'h2);
                pendAddr_r <= haddr[13:0];
            end
            if (pend_r) begin
                hrdata <= rdValue;
            end
        end
    end

    // OKAY is the only answer this slave gives
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ****************************************************************
    // Command staging
    // ****************************************************************
    // command length and words
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmdLen_r <= 11'h000;
        end else if (busWr && pendAddr_r == esr_pkg::ADDR_CMD_LEN) begin
            cmdLen_r <= hwdata[10:0];
        end
    end

    // No reset on packet words; contents are defined by software
    always_ff @(posedge ref_clk) begin
        if (busWr && cmdHit) begin
            cmdMem[wordIdx] <= hwdata[15:0];
        end
    end

    // ****************************************************************
    // Router word decode
    // ****************************************************************
    wire [15:0] router = cmdMem[0];
    wire [11:0] svcNum = router[11:0];
    // malformed command is a router error
    wire routerErr = router[esr_pkg::DIR_BIT] || router[esr_pkg::RSVD_BIT] ||
        (router[esr_pkg::STAT_HI:esr_pkg::STAT_LO] != esr_pkg::RSTAT_NORMAL) ||
        (cmdLen_r < esr_pkg::LEN_MIN) || (cmdLen_r > esr_pkg::LEN_MAX);
    wire modelSvc = (svcNum >= esr_pkg::SVC_MODEL_FIRST) && (svcNum <= esr_pkg::SVC_MODEL_LAST);
    wire commonSvc = (svcNum <= esr_pkg::SVC_CLOCK_SET);
    wire svcExists = commonSvc || modelSvc;
    wire [3:0] handlerIdx = modelSvc ? 4'(svcNum - esr_pkg::SVC_MODEL_FIRST + 12'h002)
        : 4'(svcNum - esr_pkg::SVC_CLOCK_READ);
    wire recipeBad = (svcNum == esr_pkg::SVC_TRANS_CTRL) && oneRecipeNeeded &&
        (cmdMem[1] == esr_pkg::SUBCMD_RECIPE) &&
        (onesCount({cmdMem[4], cmdMem[5], cmdMem[2], cmdMem[3]}) != 7'h01);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    wire [8:0] lastWord = 9'(workLen_r[10:1] - 10'h001);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ESR_IDLE: if (startPulse) state_nxt = ESR_DECODE;
            ESR_DECODE: state_nxt = (!memPacking && !routerErr && svcExists &&
                svcNum != esr_pkg::SVC_UNIT_INFO && !recipeBad) ? ESR_WAIT : ESR_BUILD;
            ESR_WAIT: if (svcRsp.done) state_nxt = ESR_BUILD;
            ESR_BUILD: if (idx_r == lastWord) state_nxt = ESR_FINISH;
            ESR_FINISH: state_nxt = ESR_IDLE;
            default: state_nxt = ESR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ESR_IDLE;
            busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy <= (state_nxt != ESR_IDLE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            code_r <= esr_pkg::CODE_OK;
            rstat_r <= esr_pkg::RSTAT_NORMAL;
            svc_r <= 12'h000;
            workLen_r <= esr_pkg::LEN_ROUTER_ONLY;
        end else if (state_r == ESR_DECODE) begin
            svc_r <= svcNum;
            code_r <= esr_pkg::CODE_OK;
            rstat_r <= esr_pkg::RSTAT_NORMAL;
            workLen_r <= esr_pkg::LEN_CODE_ONLY;
            if (memPacking) begin
                code_r <= esr_pkg::CODE_PACKING;
            end else if (routerErr) begin
                rstat_r <= esr_pkg::RSTAT_ROUTER_ERR;
                workLen_r <= esr_pkg::LEN_ROUTER_ONLY;
            end else if (!svcExists) begin
                rstat_r <= esr_pkg::RSTAT_NO_SVC;
                workLen_r <= esr_pkg::LEN_ROUTER_ONLY;
            end else if (svcNum == esr_pkg::SVC_UNIT_INFO) begin
                workLen_r <= esr_pkg::LEN_UNIT_INFO;
            end else if (recipeBad) begin
                code_r <= esr_pkg::CODE_ONE_RECIPE;
            end
        end else if (state_r == ESR_WAIT && svcRsp.done) begin
            code_r <= svcRsp.code;
        end
    end

    // handler request, held until the handler completes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            svcReq <= '0;
        end else if (state_r == ESR_DECODE && state_nxt == ESR_WAIT) begin
            svcReq <= '{valid: 1'b1, handler: handlerIdx, service: svcNum};
        end else if (svcRsp.done) begin
            svcReq <= '0;
        end
    end

    // ****************************************************************
    // Response assembly
    // ****************************************************************
    // response router word
    wire [15:0] rspRouter = {1'b1, 1'b0, rstat_r, svc_r};
    logic [15:0] rspWord;

    // unit information words; serial field left zero
    always_comb begin
        case (idx_r)
            9'h000: rspWord = rspRouter;
            9'h001: rspWord = code_r;
            esr_pkg::UI_MFR: rspWord = MFR_CODE;
            esr_pkg::UI_MODEL: rspWord = MODEL_CODE;
            esr_pkg::UI_FW: rspWord = FW_REV;
            esr_pkg::UI_CRC_HI: rspWord = ROM_CRC[31:16];
            esr_pkg::UI_CRC_LO: rspWord = ROM_CRC[15:0];
            default: rspWord = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (state_r == ESR_BUILD) begin
            rspMem[idx_r] <= rspWord;
        end
    end

    // Word counter and published length
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            idx_r <= 9'h000;
            rspLen_r <= 11'h000;
        end else begin
            idx_r <= (state_r == ESR_BUILD) ? idx_r + 9'h001 : 9'h000;
            if (state_r == ESR_FINISH) begin
                rspLen_r <= workLen_r;
            end
        end
    end

    // Done flag; a new completion wins over a clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_r <= 1'b0;
        end else if (state_r == ESR_FINISH) begin
            done_r <= 1'b1;
        end else if (clearDone) begin
            done_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_router_dir: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_BUILD && idx_r == 9'h000 |=> rspMem[0][15] && !rspMem[0][14])
        else $error("response router word lacks direction bit");
    chk_status_len: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_FINISH && rstat_r != esr_pkg::RSTAT_NORMAL |=> rspLen_r == 11'h002)
        else $error("error response carries data");
    chk_no_svc: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_DECODE && !memPacking && !routerErr && !svcExists
        |=> rstat_r == esr_pkg::RSTAT_NO_SVC)
        else $error("missing service not flagged");
    chk_echo_svc: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_DECODE |=> svc_r == $past(svcNum))
        else $error("service number not echoed");
    chk_model_map: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(svcReq.valid) && svcReq.service >= esr_pkg::SVC_MODEL_FIRST
        |-> svcReq.handler == 4'(svcReq.service - 12'h3fe))
        else $error("model handler index wrong");
    chk_packing: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_DECODE && memPacking |=> code_r == 16'h8030 ##1 state_r == ESR_BUILD)
        else $error("packing code not returned");
    chk_recipe: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_DECODE && !memPacking && !routerErr && recipeBad |=> code_r == 16'h8024)
        else $error("recipe code not returned");
    chk_unit_len: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_DECODE && !memPacking && !routerErr && svcNum == 12'h000
        |=> ##16 rspLen_r == 11'h01e)
        else $error("unit information length wrong");
    chk_code_class: assert property (@(posedge ref_clk) disable iff (reset)
        pend_r && !pendWrite_r && pendAddr_r == esr_pkg::ADDR_RESULT &&
        code_r >= 16'h8000 && code_r <= 16'hbfff |=> hrdata[17:16] == 2'h2)
        else $error("critical class misdecoded");
    chk_done_win: assert property (@(posedge ref_clk) disable iff (reset)
        state_r == ESR_FINISH |=> done_r && busy == (state_r != ESR_IDLE))
        else $error("completion flag lost");
endmodule : esr_router
`default_nettype wire

// ==== dv/esr_handler_model.sv ====
// Behavioural model of an outside service handler.
`timescale 1ns/1ps
`default_nettype none
module esr_handler_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire esr_pkg::esr_svc_req_t svcReq,
    input wire logic [15:0] rspCode,
    input wire logic [3:0] rspDelay,
    output esr_pkg::esr_svc_rsp_t svcRsp,
    output logic [3:0] lastHandler,
    output logic [11:0] lastService
);
    logic [3:0] waitCnt_r;
    logic served_r;
    // one code per request
    // Done pulses once; the wait varies so slow handlers are exercised too
    always_ff @(posedge ref_clk) begin
        svcRsp <= '0;
        if (reset || !svcReq.valid) begin
            waitCnt_r <= '0;
            served_r <= 1'b0;
        end else if (!served_r) begin
            lastHandler <= svcReq.handler;
            lastService <= svcReq.service;
            if (waitCnt_r == rspDelay) begin
                svcRsp <= {1'b1, rspCode};
                served_r <= 1'b1;
            end else begin
                waitCnt_r <= waitCnt_r + 4'h1;
            end
        end
    end
endmodule : esr_handler_model
`default_nettype wire

// ==== dv/extended_service_router_tb_top.sv ====
// Self-checking bench for the extended service router.
`timescale 1ns/1ps
`default_nettype none
module extended_service_router_tb_top;
    localparam logic [15:0] MFR = 16'h00c3; // Arbitrary identity value
    localparam logic [15:0] MODEL = 16'h003c; // Arbitrary identity value
    localparam logic [15:0] FWREV = 16'h0203;
    localparam logic [31:0] CRC = 32'h1234_abcd;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic busy;
    logic memPacking = 1'b0;
    logic oneRecipeNeeded = 1'b0;
    esr_pkg::esr_svc_rsp_t svcRsp;
    esr_pkg::esr_svc_req_t svcReq;
    logic [15:0] rspCode = '0;
    logic [3:0] rspDelay = '0;
    logic [3:0] lastHandler;
    logic [11:0] lastService;
    logic [31:0] seed = 32'h0000_000a;
    logic [31:0] rd, rl, res;
    logic [11:0] sv;
    logic [15:0] cmd [6];
    logic [15:0] exw [15];
    logic [11:0] svcs [10] = '{12'h001, 12'h002, 12'h400, 12'h401, 12'h402,
        12'h403, 12'h404, 12'h405, 12'h406, 12'h407};
    logic [11:0] unk [6] = '{12'h003, 12'h0ff, 12'h100, 12'h3ff, 12'h408, 12'hfff};
    logic [15:0] bad [6] = '{16'h4001, 16'h1002, 16'h2400, 16'h8000, 16'h0000, 16'h0000};
    logic [10:0] badLen [6] = '{11'd2, 11'd2, 11'd2, 11'd2, 11'd1, 11'd1026};
    int n_fail = 0;
    int cmp_count = 0;

    esr_router #(.MFR_CODE(MFR), .MODEL_CODE(MODEL), .FW_REV(FWREV), .ROM_CRC(CRC))
    esr_router_inst (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .memPacking(memPacking), .oneRecipeNeeded(oneRecipeNeeded), .svcRsp(svcRsp),
        .svcReq(svcReq), .busy(busy));
    esr_handler_model esr_handler_model_inst (.ref_clk(ref_clk), .reset(reset),
        .svcReq(svcReq), .rspCode(rspCode), .rspDelay(rspDelay), .svcRsp(svcRsp),
        .lastHandler(lastHandler), .lastService(lastService));

    // Free-running bus clock
    always #12.5 ref_clk = ~ref_clk;

    // ****************************************************************
    // Expectation helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Response router word: direction set, reserved clear
    function automatic logic [15:0] rword(input logic [1:0] st, input logic [11:0] s);
        return {1'b1, 1'b0, st, s};
    endfunction : rword

    // Severity class by code range
    function automatic logic [31:0] cls(input logic [15:0] c);
        return c >= 16'hc000 ? 3 : c >= 16'h8000 ? 2 : c >= 16'h4000 ? 1 : 0;
    endfunction : cls

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // One single AHB-Lite word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        chk(32'(n < 50), 32'h1, "bus wait");
        chk(32'(hresp), 32'h0, "response not okay");
        if (n >= 50) end_sim();
    endtask : bus

    // Stage a packet, start it, poll for done, fetch length and result
    task automatic run(input logic [10:0] len, input int nw);
        int n;
        for (int i = 0; i < nw; i++) bus(1'b1, 32'h1000 + 32'(4 * i), {16'h0, cmd[i]});
        bus(1'b1, 32'h0, {21'h0, len});
        bus(1'b1, 32'h4, 32'h1);
        n = 0;
        do begin bus(1'b0, 32'h4, '0); n++; end while (rd[1] !== 1'b1 && n < 100);
        chk(32'(n < 100), 32'h1, "done wait");
        if (n >= 100) end_sim();
        chk(32'(busy), 32'h0, "busy after done");
        bus(1'b0, 32'h8, '0);
        rl = rd;
        bus(1'b0, 32'hc, '0);
        res = rd;
        bus(1'b1, 32'h4, 32'h2);
    endtask : run

    // Compare response words against exw
    task automatic rsp(input int nw);
        for (int i = 0; i < nw; i++) begin
            bus(1'b0, 32'h2000 + 32'(4 * i), '0);
            chk(rd, {16'h0, exw[i]}, "response word");
        end
    endtask : rsp

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        bus(1'b0, 32'h4, '0);
        chk(rd, 32'h0, "control after reset");
        bus(1'b0, 32'h3000, '0);
        chk(rd, 32'h0, "unmapped read");
        // Unit information with a bare router word
        cmd[0] = 16'h0000;
        run(11'd2, 1);
        exw = '{default: 16'h0};
        exw[0] = 16'h8000;
        exw[2] = MFR;
        exw[3] = MODEL;
        exw[12] = FWREV;
        exw[13] = CRC[31:16];
        exw[14] = CRC[15:0];
        chk(rl, 32'd30, "info length");
        bus(1'b0, 32'h0, '0);
        chk(rd, 32'h2, "command length");
        rsp(15);
        chk(32'(res[20]), 32'h1, "common range");
        // Every handled service, random codes over all four classes
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            rspCode <= {2'(k % 4), seed[13:0]};
            rspDelay <= seed[19:16];
            cmd[0] = {4'h0, svcs[k]};
            cmd[1] = 16'h0;
            run(11'd4, 2);
            chk(32'(lastHandler), 32'(k), "handler");
            chk(32'(lastService), 32'(svcs[k]), "service");
            chk(rl, 32'd4, "length");
            exw[0] = rword(2'h0, svcs[k]);
            exw[1] = rspCode;
            rsp(2);
            chk(32'(res[17:16]), cls(rspCode), "class");
            chk(32'(res[20]), 32'(svcs[k] < 12'h100), "range");
        end
        // Missing services, corners then random
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            sv = k < 6 ? unk[k] : (12'h408 | seed[11:0]);
            cmd[0] = {4'h0, sv};
            run(11'd2, 1);
            chk(rl, 32'd2, "missing length");
            exw[0] = rword(2'h1, sv);
            rsp(1);
            chk(32'(res[19:18]), 32'h1, "missing status");
        end
        // Malformed commands
        for (int k = 0; k < 6; k++) begin
            cmd[0] = bad[k];
            run(badLen[k], 1);
            chk(rl, 32'd2, "error length");
            exw[0] = rword(2'h2, bad[k][11:0]);
            rsp(1);
        end
        // Memory compaction wins over dispatch
        memPacking <= 1'b1;
        cmd[0] = 16'h0400;
        cmd[1] = 16'h0;
        run(11'd4, 2);
        memPacking <= 1'b0;
        exw[0] = 16'h8400;
        exw[1] = 16'h8030;
        rsp(2);
        chk(rl, 32'd4, "packing length");
        chk(32'(res[17:16]), 32'h2, "packing class");
        // Recipe allocation with two, then one recipe enabled
        oneRecipeNeeded <= 1'b1;
        cmd = '{16'h0400, 16'h0002, 16'h0021, 16'h0, 16'h0, 16'h0};
        run(11'd12, 6);
        exw[1] = 16'h8024;
        rsp(2);
        cmd[2] = 16'h0020;
        rspCode <= 16'h0001;
        run(11'd12, 6);
        exw[1] = 16'h0001;
        rsp(2);
        end_sim();
    end
endmodule : extended_service_router_tb_top
`default_nettype wire
